// File: design/crs_chip_reset_sequencer.v
// Contract
// R1: Internal reset is asserted for power-on, voltage detect, pin, watchdog, frequency detect or software request.
// R2: The source of the last reset is recorded in readable reset cause flags.
// R3: After power-on release a power-up counter runs about 3.2 ms before internal reset releases.
// R4: The reset pin is ignored until the power-up counter has finished.
// R5: A pin released within 3.2 ms of power-on gives exactly the plain power-on sequence.
// R6: The board holds the reset pin low at least 12 internal oscillator cycles.
// R7: After a valid pin reset, internal reset releases once the pin returns high.
// R8: Every reset returns core and peripheral control registers to initial values.
// R9: Debug units, cause flags and flash security bit clear only on a cold reset; cause flags are rewritten on each warm reset entry from run here.
// R10: After release the chip runs on the internal oscillator with external clock and PLL off.
// R11: RAM contents are not kept across any reset.
// R12: Power-up inserts an automatic stabilisation wait for regulator, flash and oscillator.
// R13: Each request is synchronised and internal reset holds while any source is active.
`timescale 1ns/1ps
`include "crs_defs.vh"

module crs_chip_reset_sequencer #(
  parameter PWRUP_CYC = (`CRS_PWRUP_TIME_US * `CRS_CLK_MHZ),
  parameter CNT_W     = 19
) (
  input  wire                   clock,
  input  wire                   nrst,
  input  wire                   ext_reset_n,
  input  wire                   supply_voltage_detector,
  input  wire                   watchdog_reset_source,
  input  wire                   oscillation_frequency_detector,
  input  wire                   core_software_reset_request,
  output reg                    sys_reset_n_ff,
  output reg                    cold_reset_n_ff,
  output reg  [`CRS_CAUSE_W-1:0] reset_cause_flags_ff,
  output reg                    flash_security_clear_ff,
  output reg                    debug_reset_n_ff,
  output reg                    pwrup_done_ff,
  output reg                    clk_sel_ext_ff,
  output reg                    pll_enable_ff
);

  // Last count value, cut to the counter width on purpose
  localparam [31:0]      PWRUP_LAST_FULL = PWRUP_CYC - 1;
  localparam [CNT_W-1:0] PWRUP_LAST      = PWRUP_LAST_FULL[CNT_W-1:0];

  // Two-stage synchronisers; first stage feeds only the second
  reg [4:0] sync1_ff;
  reg [4:0] sync2_ff;
  wire [4:0] raw_req = {core_software_reset_request, oscillation_frequency_detector,
                        watchdog_reset_source, supply_voltage_detector, ~ext_reset_n};

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync1_ff <= 5'h00;
      sync2_ff <= 5'h00;
    end else begin
      sync1_ff <= raw_req; // R13
      sync2_ff <= sync1_ff; // R13
    end
  end

  wire pin_req = sync2_ff[0];
  wire vlt_req = sync2_ff[1];
  wire wdg_req = sync2_ff[2];
  wire fdet_req = sync2_ff[3];
  wire sys_req = sync2_ff[4];

  // Pin counts only after power-up; earlier lows fold into the power-on wait
  wire pin_eff  = pin_req & pwrup_done_ff; // R4 R5
  wire warm_any = pin_eff | vlt_req | wdg_req | fdet_req | sys_req; // R1 R13

  reg [`CRS_ST_W-1:0] state_ff;
  reg [`CRS_ST_W-1:0] nxt_state;
  reg [CNT_W-1:0]     cnt_ff;
  reg [CNT_W-1:0]     nxt_cnt;
  reg                 nxt_pwrup_done;

  // Sequencer: power-up wait, run, warm-reset hold
  always @* begin
    nxt_state      = state_ff;
    nxt_cnt        = cnt_ff;
    nxt_pwrup_done = pwrup_done_ff;
    case (state_ff)
      `CRS_ST_PWRUP: begin
        if (cnt_ff == PWRUP_LAST) begin // R3 R12
          nxt_pwrup_done = 1'b1;
          nxt_state      = warm_any ? `CRS_ST_WARM : `CRS_ST_RUN;
        end else begin
          nxt_cnt = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
      `CRS_ST_RUN: begin
        if (warm_any) begin
          nxt_state = `CRS_ST_WARM; // R1
        end
      end
      `CRS_ST_WARM: begin
        if (!warm_any) begin
          nxt_state = `CRS_ST_RUN; // R7 R13
        end
      end
      default: begin
        nxt_state = `CRS_ST_PWRUP;
      end
    endcase
  end

  // Power-on reset is nrst itself: the only cold reset
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_ff      <= `CRS_ST_PWRUP;
      cnt_ff        <= {CNT_W{1'b0}};
      pwrup_done_ff <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      cnt_ff        <= nxt_cnt;
      pwrup_done_ff <= nxt_pwrup_done;
    end
  end

  // Reset outputs; system reset also drops RAM guarantees downstream
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sys_reset_n_ff  <= 1'b0;
      cold_reset_n_ff <= 1'b0;
      debug_reset_n_ff <= 1'b0;
      flash_security_clear_ff <= 1'b1;
    end else begin
      sys_reset_n_ff  <= (nxt_state == `CRS_ST_RUN); // R8 R11
      cold_reset_n_ff <= nxt_pwrup_done; // R9
      debug_reset_n_ff <= nxt_pwrup_done; // R9
      flash_security_clear_ff <= ~nxt_pwrup_done; // R9
    end
  end

  // Cause flags: cold reset sets only the POR flag; each warm entry from run overwrites all flags with its causes
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reset_cause_flags_ff <= {{(`CRS_CAUSE_W-1){1'b0}}, 1'b1}; // R2 R9
    end else if (state_ff == `CRS_ST_RUN && warm_any) begin
      reset_cause_flags_ff[`CRS_CAUSE_POR] <= 1'b0;
      reset_cause_flags_ff[`CRS_CAUSE_VLT] <= vlt_req; // R2
      reset_cause_flags_ff[`CRS_CAUSE_PIN] <= pin_eff;
      reset_cause_flags_ff[`CRS_CAUSE_WDG] <= wdg_req;
      reset_cause_flags_ff[`CRS_CAUSE_FDET] <= fdet_req;
      reset_cause_flags_ff[`CRS_CAUSE_SYS] <= sys_req;
    end
  end

  // Clock selection returns to internal oscillator on any reset
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      clk_sel_ext_ff <= `CRS_CLKSEL_INT;
      pll_enable_ff  <= 1'b0;
    end else if (nxt_state != `CRS_ST_RUN) begin
      clk_sel_ext_ff <= `CRS_CLKSEL_INT; // R10
      pll_enable_ff  <= 1'b0; // R10
    end
  end

endmodule

// File: design/crs_defs.vh
`ifndef CRS_DEFS_VH
`define CRS_DEFS_VH
// Power-up stabilisation time in microseconds
`define CRS_PWRUP_TIME_US     3200
// Clock rate in MHz
`define CRS_CLK_MHZ           125
// Least pin-low length in internal oscillator cycles
`define CRS_PIN_MIN_CYC       12
// Reset cause flag bit positions
`define CRS_CAUSE_POR         0
`define CRS_CAUSE_VLT         1
`define CRS_CAUSE_PIN         2
`define CRS_CAUSE_WDG         3
`define CRS_CAUSE_FDET        4
`define CRS_CAUSE_SYS         5
`define CRS_CAUSE_W           6
// Sequencer states
`define CRS_ST_PWRUP          2'h0
`define CRS_ST_RUN            2'h1
`define CRS_ST_WARM           2'h2
`define CRS_ST_W              2
// Clock source select after reset: internal oscillator
`define CRS_CLKSEL_INT        1'h0
`endif

// File: verif/crs_board_model.sv
`timescale 1ns/1ps
// Board pin driver: a go pulse pulls the pin low for len+12 cycles
module crs_board_model (
  input  wire       clock,
  input  wire       go,
  input  wire [4:0] len,
  output reg        ext_reset_n
);
  reg [5:0] cnt_ff = 6'h00;
  initial ext_reset_n = 1'b1;
  // Never shorter than 12 low cycles, a retrigger while low is ignored
  always @(posedge clock) begin
    if (go && cnt_ff == 6'h00) begin
      cnt_ff <= {1'b0, len} + 6'h0C;
      ext_reset_n <= 1'b0;
    end else if (cnt_ff != 6'h00) begin
      cnt_ff <= cnt_ff - 6'h01;
      ext_reset_n <= (cnt_ff == 6'h01);
    end
  end
endmodule

// File: verif/crs_chip_reset_sequencer_asserts.sv
`timescale 1ns/1ps
module crs_seq_asserts #(parameter PWRUP_CYC = 20, parameter CNT_W = 19) (
  input wire       clock, nrst, ext_reset_n, supply_voltage_detector,
  input wire       watchdog_reset_source, oscillation_frequency_detector,
  input wire       core_software_reset_request, sys_reset_n_ff, cold_reset_n_ff,
  input wire       flash_security_clear_ff, debug_reset_n_ff, pwrup_done_ff,
  input wire       clk_sel_ext_ff, pll_enable_ff,
  input wire [5:0] reset_cause_flags_ff
);
  wire w = supply_voltage_detector | watchdog_reset_source
         | oscillation_frequency_detector | core_software_reset_request;
  reg [CNT_W-1:0] cnt_ff;
  // Cycles since power-on release, frozen once the wait ends
  always @(posedge clock or negedge nrst)
    if (!nrst) cnt_ff <= {CNT_W{1'b0}};
    else if (!pwrup_done_ff) cnt_ff <= cnt_ff + 1'b1;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_quiet; !w && ext_reset_n; endsequence
  a_req_reset: assert property ((w || !ext_reset_n) && pwrup_done_ff |-> ##[1:4] !sys_reset_n_ff)
    else $error("request gave no reset");
  a_hold_req: assert property (w [*4] |-> !sys_reset_n_ff)
    else $error("reset released under request");
  a_quiet_release: assert property (s_quiet [*5] ##0 pwrup_done_ff |-> sys_reset_n_ff)
    else $error("reset not released");
  a_pwrup_count: assert property ($rose(pwrup_done_ff) |-> cnt_ff == PWRUP_CYC)
    else $error("power-up wait length wrong");
  a_pwrup_hold: assert property (!pwrup_done_ff |-> !sys_reset_n_ff && !cold_reset_n_ff
    && !debug_reset_n_ff && flash_security_clear_ff) else $error("reset left during wait");
  a_pin_ignored: assert property ($rose(pwrup_done_ff) && !w && !$past(w) && !$past(w, 2)
    |-> sys_reset_n_ff) else $error("pin acted during wait");
  a_warm_keeps: assert property (pwrup_done_ff |-> cold_reset_n_ff && debug_reset_n_ff
    && !flash_security_clear_ff) else $error("warm reset hit cold state");
  a_int_clock: assert property (!clk_sel_ext_ff && !pll_enable_ff)
    else $error("clock not internal");
  a_cause_entry: assert property ($fell(sys_reset_n_ff) && pwrup_done_ff |-> reset_cause_flags_ff ==
    {core_software_reset_request, oscillation_frequency_detector, watchdog_reset_source,
    !ext_reset_n, supply_voltage_detector, 1'b0}) else $error("cause flags wrong");
  a_cause_stable: assert property (sys_reset_n_ff && $past(sys_reset_n_ff)
    |-> $stable(reset_cause_flags_ff)) else $error("cause flags moved");
endmodule

// File: verif/crs_chip_reset_sequencer_bench.sv
`timescale 1ns/1ps
`include "crs_defs.vh"
module crs_chip_reset_sequencer_bench;
  localparam PC = 20; // Short power-up wait keeps the run brief
  reg        clock = 1'b0, nrst = 1'b0, go = 1'b0;
  reg  [3:0] req = 4'h0;
  reg  [4:0] len = 5'h00;
  wire       ext_n, sys_n, cold_n, fl_clr, dbg_n, pdone, csel, pll;
  wire [5:0] cause;
  integer    num_errors = 0, num_checks = 0, seed = 47, i, k;
  always #4 clock = ~clock;
  crs_board_model crs_board_model_inst (.clock(clock), .go(go), .len(len), .ext_reset_n(ext_n));
  crs_chip_reset_sequencer #(.PWRUP_CYC(PC)) crs_chip_reset_sequencer_inst (.clock(clock),
    .nrst(nrst), .ext_reset_n(ext_n), .supply_voltage_detector(req[0]),
    .watchdog_reset_source(req[1]), .oscillation_frequency_detector(req[2]),
    .core_software_reset_request(req[3]), .sys_reset_n_ff(sys_n), .cold_reset_n_ff(cold_n),
    .reset_cause_flags_ff(cause), .flash_security_clear_ff(fl_clr), .debug_reset_n_ff(dbg_n),
    .pwrup_done_ff(pdone), .clk_sel_ext_ff(csel), .pll_enable_ff(pll));
  // Source 0..3 are the level requests, 4 is the pin
  function [5:0] ecause(input integer s);
    ecause = 6'h01 << (s == 0 ? `CRS_CAUSE_VLT : s == 1 ? `CRS_CAUSE_WDG :
      s == 2 ? `CRS_CAUSE_FDET : s == 3 ? `CRS_CAUSE_SYS : `CRS_CAUSE_PIN);
  endfunction
  task tick(input integer n); repeat (n) @(posedge clock); #1; endtask
  task chk(input string nm, input [5:0] seen, input [5:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task summarize;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Bounded wait for release; a hang ends the run
  task wait_hi;
    for (k = 0; k < 40 && sys_n !== 1'b1; k = k + 1) tick(1);
    if (k == 40) begin num_errors = num_errors + 1; summarize; end
  endtask
  initial begin
    tick(12); nrst <= 1'b1; go <= 1'b1; len <= 5'h01;
    tick(1); go <= 1'b0;
    tick(PC); chk("sys", sys_n, 6'h01);
    chk("cause", cause, 6'h01);
    for (i = 0; i < 5; i = i + 1) begin
      len <= $random(seed);
      if (i < 4) req <= 4'h1 << i; else go <= 1'b1;
      tick(4); go <= 1'b0;
      chk("sys", sys_n, 6'h00);
      chk("cause", cause, ecause(i));
      tick(8 + len); req <= 4'h0; wait_hi;
      chk("cold", {cold_n, dbg_n, fl_clr, csel, pll}, 6'h18);
      chk("kept", cause, ecause(i));
    end
    req <= 4'h2; tick(5); req <= 4'h3; tick(3); req <= 4'h1; tick(6);
    chk("overlap", sys_n, 6'h00); req <= 4'h0; wait_hi;
    nrst <= 1'b0; tick(2); chk("cold", cause, 6'h01); nrst <= 1'b1;
    chk("coldout", {cold_n, dbg_n, fl_clr, csel, pll}, 6'h04);
    tick(PC + 2); chk("rerun", sys_n, 6'h01);
    summarize;
  end
endmodule
bind crs_chip_reset_sequencer crs_seq_asserts #(.PWRUP_CYC(PWRUP_CYC), .CNT_W(CNT_W)) crs_seq_asserts_inst (
  .clock(clock), .nrst(nrst), .ext_reset_n(ext_reset_n),
  .supply_voltage_detector(supply_voltage_detector), .watchdog_reset_source(watchdog_reset_source),
  .oscillation_frequency_detector(oscillation_frequency_detector),
  .core_software_reset_request(core_software_reset_request), .sys_reset_n_ff(sys_reset_n_ff),
  .cold_reset_n_ff(cold_reset_n_ff), .flash_security_clear_ff(flash_security_clear_ff),
  .debug_reset_n_ff(debug_reset_n_ff), .pwrup_done_ff(pwrup_done_ff),
  .clk_sel_ext_ff(clk_sel_ext_ff), .pll_enable_ff(pll_enable_ff),
  .reset_cause_flags_ff(reset_cause_flags_ff));
